// file: rtl/io_sample_pkg.sv
// constants, types and helpers for the I/O sample record builder
package io_sample_pkg;
   localparam int NUM_LINES = 13;
   localparam int NUM_AN    = 4;
   localparam int ADC_W     = 12;
   localparam int REC_MAX   = 14;
   localparam int REC_BITS  = REC_MAX * 8;
   localparam int IDX_W     = 4;
   localparam int FIFO_DEPTH = 8;

   localparam logic [7:0]  SAMPLE_SET_COUNT = 8'h01;
   localparam logic [15:0] FULL_SCALE       = 16'h03FF;
   localparam logic        REF_2V5          = 1'b1;
   localparam logic [7:0]  ASCII_CR         = 8'h0D;
   localparam logic [7:0]  ASCII_ZERO       = 8'h30;
   localparam logic [7:0]  ASCII_A_LESS_10  = 8'h37;

   // command response frame pieces
   localparam logic [7:0] API_START     = 8'h7E;
   localparam logic [7:0] API_LEN_HI    = 8'h00;
   localparam logic [7:0] API_TYPE_RESP = 8'h88;
   localparam logic [7:0] API_CMD_HI    = 8'h49;
   localparam logic [7:0] API_CMD_LO    = 8'h53;
   localparam logic [7:0] API_STATUS_OK = 8'h00;
   localparam logic [7:0] API_OVERHEAD  = 8'h05;
   localparam logic [7:0] API_CK_BASE   = 8'hFF;
   localparam logic [2:0] HDR_LEN_HI    = 3'h1;
   localparam logic [2:0] HDR_LEN_LO    = 3'h2;
   localparam logic [2:0] HDR_TYPE      = 3'h3;
   localparam logic [2:0] HDR_FID       = 3'h4;
   localparam logic [2:0] HDR_CMD_HI    = 3'h5;
   localparam logic [2:0] HDR_CMD_LO    = 3'h6;
   localparam logic [2:0] HDR_LAST      = 3'h7;

   localparam logic [1:0] PH_HI = 2'h0;
   localparam logic [1:0] PH_LO = 2'h1;
   localparam logic [1:0] PH_CR = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_CONV  = 3'b001,
      ST_WAIT  = 3'b010,
      ST_HDR   = 3'b011,
      ST_BODY  = 3'b100,
      ST_CKSUM = 3'b101
   } state_t;

   typedef struct packed {
      logic [7:0] data;
      logic       last;
      logic       remote;
      logic [7:0] dest;
   } out_word_t;

   localparam int WORD_W = $bits(out_word_t);

   function automatic logic [7:0] nibble_ascii(input logic [3:0] n);
      nibble_ascii = (n < 4'hA) ? ASCII_ZERO + {4'h0, n}
                                : ASCII_A_LESS_10 + {4'h0, n};
   endfunction

   function automatic logic [IDX_W-1:0] rec_length(input logic [15:0] dm,
                                                    input logic [3:0]  am);
      logic [IDX_W-1:0] n;
      n = IDX_W'(4);
      if (|dm) n = n + IDX_W'(2);
      for (int c = 0; c < NUM_AN; c++)
         if (am[c]) n = n + IDX_W'(2);
      rec_length = n;
   endfunction
endpackage

// file: rtl/line_sync.sv
// three-stage synchroniser for pin inputs with agreement filter
`timescale 1ns/10ps
module line_sync
   import io_sample_pkg::*;
#(
   parameter int W = NUM_LINES
) (
   input  wire logic         sys_clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // a bit only moves once stages two and three agree
   wire  [W-1:0] agree = ~(s2_q ^ s3_q);

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_q    <= '0;
         s2_q    <= '0;
         s3_q    <= '0;
         level_o <= '0;
      end else begin
         s1_q    <= pin_i;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         level_o <= (agree & s2_q) | (~agree & level_o);
      end
   end
endmodule // line_sync

// file: rtl/sample_fifo.sv
// byte fifo with registered output stage
`timescale 1ns/10ps
module sample_fifo #(
   parameter int W     = 18,
   parameter int DEPTH = 8
) (
   input  wire logic         sys_clk_i,
   input  wire logic         rst_i,
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   output logic              out_valid_o,
   output logic      [W-1:0] out_data_o,
   input  wire logic         out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [CW-1:0] count_q;

   wire empty = (count_q == '0);
   wire full  = (count_q == CW'(DEPTH));
   wire push  = in_valid_i && !full;
   wire pop   = !empty && (!out_valid_o || out_ready_i);

   assign in_ready_o = !full;

   always_ff @(posedge sys_clk_i) begin
      if (push) mem[wr_q] <= in_data_i;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_q    <= '0;
         rd_q    <= '0;
         count_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + AW'(1);
         if (pop) rd_q <= rd_q + AW'(1);
         count_q <= count_q + CW'(push) - CW'(pop);
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
      end else if (pop) begin
         out_valid_o <= 1'b1;
         out_data_o  <= mem[rd_q];
      end else if (out_ready_i) begin
         out_valid_o <= 1'b0;
      end
   end
endmodule // sample_fifo

// file: rtl/io_sample_packet_builder.sv
// queried I/O sample record builder with text, frame and remote output
`timescale 1ns/10ps
module io_sample_packet_builder
   import io_sample_pkg::*;
(
   input  wire logic                 sys_clk_i,
   input  wire logic                 rst_i,
   input  wire logic [NUM_LINES-1:0] general_line_i,
   input  wire logic [NUM_LINES-1:0] digital_enable_i,
   input  wire logic [NUM_AN-1:0]    analog_enable_i,
   input  wire logic                 analog_reference_select_i,
   input  wire logic                 api_mode_i,
   input  wire logic                 sample_query_cmd_i,
   input  wire logic                 query_remote_i,
   input  wire logic [7:0]           query_source_i,
   input  wire logic [7:0]           query_frame_id_i,
   output logic                      query_ready_o,
   output logic                      adc_start_o,
   output logic [1:0]                adc_channel_o,
   output logic                      analog_ref_sel_o,
   input  wire logic                 adc_done_i,
   input  wire logic [ADC_W-1:0]     adc_value_i,
   output logic                      out_valid_o,
   output logic [7:0]                out_data_o,
   output logic                      out_last_o,
   output logic                      out_remote_o,
   output logic [7:0]                out_dest_o,
   input  wire logic                 out_ready_i
);
   state_t                  state_q;
   state_t                  state_d;
   logic [NUM_LINES-1:0]    line_level;
   logic [15:0]             dmask_q;
   logic [3:0]              amask_q;
   logic [15:0]             dstate_q;
   logic [NUM_AN-1:0][15:0] an_q;
   logic                    remote_q;
   logic                    api_q;
   logic [7:0]              dest_q;
   logic [7:0]              fid_q;
   logic [1:0]              ch_q;
   logic [IDX_W-1:0]        idx_q;
   logic [1:0]              ph_q;
   logic [2:0]              hdr_q;
   logic [7:0]              sum_q;
   logic                    fifo_ready;
   out_word_t               fifo_out;

   line_sync #(
      .W (NUM_LINES)
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .pin_i     (general_line_i),
      .level_o   (line_level)
   );

   // record packed msb-first, left-justified in REC_BITS
   function automatic logic [REC_BITS-1:0] pack_record(
      input logic [15:0] dm,
      input logic [3:0]  am,
      input logic [15:0] ds,
      input logic [63:0] an);
      logic [REC_BITS-1:0] r;
      int                  n;
      r = '0;
      n = 4;
      r = {r[REC_BITS-33:0], SAMPLE_SET_COUNT, dm, 4'h0, am};
      if (|dm) begin
         r = {r[REC_BITS-17:0], ds};
         n = n + 2;
      end
      for (int c = 0; c < NUM_AN; c++) begin
         if (am[c]) begin
            r = {r[REC_BITS-17:0], an[c*16 +: 16]};
            n = n + 2;
         end
      end
      pack_record = r << (8 * (REC_MAX - n));
   endfunction

   // flag per record byte: last byte of its field
   function automatic logic [REC_MAX-1:0] pack_field_end(
      input logic [15:0] dm,
      input logic [3:0]  am);
      logic [REC_MAX-1:0] e;
      int                 n;
      e = '0;
      n = 4;
      e = {e[REC_MAX-5:0], 4'b1011};
      if (|dm) begin
         e = {e[REC_MAX-3:0], 2'b01};
         n = n + 2;
      end
      for (int c = 0; c < NUM_AN; c++) begin
         if (am[c]) begin
            e = {e[REC_MAX-3:0], 2'b01};
            n = n + 2;
         end
      end
      pack_field_end = e << (REC_MAX - n);
   endfunction

   // query decode
   wire [15:0] dig_en = {{(16-NUM_LINES){1'b0}}, digital_enable_i};
   wire any_enabled   = (|digital_enable_i) || (|analog_enable_i);
   wire take_query    = (state_q == ST_IDLE) && sample_query_cmd_i;
   wire start_query   = take_query && any_enabled;

   // conversion decode
   wire [ADC_W-1:0] fs_code = FULL_SCALE[ADC_W-1:0];
   wire [15:0] adc_sat = (adc_value_i > fs_code) ? FULL_SCALE
                       : {{(16-ADC_W){1'b0}}, adc_value_i};
   wire ch_enabled  = amask_q[ch_q];
   wire ch_final    = (ch_q == 2'(NUM_AN - 1));
   wire text_mode   = !api_q && !remote_q;
   wire framed_mode = api_q && !remote_q;
   state_t emit_first;
   assign emit_first = framed_mode ? ST_HDR : ST_BODY;

   // record view
   wire [REC_BITS-1:0]  rec     = pack_record(dmask_q, amask_q, dstate_q,
                                              an_q);
   wire [REC_MAX-1:0]   fend    = pack_field_end(dmask_q, amask_q);
   wire [IDX_W-1:0]     rec_len = rec_length(dmask_q, amask_q);
   wire [REC_BITS-1:0]  rec_sh  = rec << {idx_q, 3'b000};
   wire [REC_MAX-1:0]   fend_sh = fend << idx_q;
   wire [7:0]           cur     = rec_sh[REC_BITS-1 -: 8];
   wire                 cur_end = fend_sh[REC_MAX-1];
   wire                 last_b  = (idx_q == rec_len - IDX_W'(1));

   // header byte selection
   wire [7:0] hdr_byte =
      (hdr_q == '0)         ? API_START :
      (hdr_q == HDR_LEN_HI) ? API_LEN_HI :
      (hdr_q == HDR_LEN_LO) ? API_OVERHEAD + {4'h0, rec_len} :
      (hdr_q == HDR_TYPE)   ? API_TYPE_RESP :
      (hdr_q == HDR_FID)    ? fid_q :
      (hdr_q == HDR_CMD_HI) ? API_CMD_HI :
      (hdr_q == HDR_CMD_LO) ? API_CMD_LO : API_STATUS_OK;

   // text rendering: two hex digits per byte, CR after each field
   wire [7:0] text_byte = (ph_q == PH_HI) ? nibble_ascii(cur[7:4]) :
                          (ph_q == PH_LO) ? nibble_ascii(cur[3:0]) :
                          ASCII_CR;

   wire [7:0] body_byte = text_mode ? text_byte : cur;
   wire byte_done = !text_mode || (ph_q == PH_CR)
                    || ((ph_q == PH_LO) && !cur_end);

   // push to fifo
   wire emitting = (state_q == ST_HDR) || (state_q == ST_BODY)
                   || (state_q == ST_CKSUM);
   wire push     = emitting && fifo_ready;
   wire body_end = (state_q == ST_BODY) && byte_done && last_b;
   wire in_sum   = ((state_q == ST_HDR) && (hdr_q >= HDR_TYPE))
                   || ((state_q == ST_BODY) && framed_mode);

   out_word_t push_word;
   assign push_word.data   = (state_q == ST_HDR)   ? hdr_byte :
                             (state_q == ST_CKSUM) ? API_CK_BASE - sum_q :
                             body_byte;
   assign push_word.last   = (state_q == ST_CKSUM)
                             || (body_end && !framed_mode);
   assign push_word.remote = remote_q;
   assign push_word.dest   = dest_q;

   sample_fifo #(
      .W     (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (emitting),
      .in_data_i   (push_word),
      .in_ready_o  (fifo_ready),
      .out_valid_o (out_valid_o),
      .out_data_o  (fifo_out),
      .out_ready_i (out_ready_i)
   );

   assign out_data_o   = fifo_out.data;
   assign out_last_o   = fifo_out.last;
   assign out_remote_o = fifo_out.remote;
   assign out_dest_o   = fifo_out.dest;

   // next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:  if (start_query) state_d = ST_CONV;
         ST_CONV:  if (ch_enabled) state_d = ST_WAIT;
                   else if (ch_final) state_d = emit_first;
         ST_WAIT:  if (adc_done_i) state_d = ch_final ? emit_first : ST_CONV;
         ST_HDR:   if (push && hdr_q == HDR_LAST) state_d = ST_BODY;
         ST_BODY:  if (push && body_end)
                      state_d = framed_mode ? ST_CKSUM : ST_IDLE;
         ST_CKSUM: if (push) state_d = ST_IDLE;
         default:  state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q       <= ST_IDLE;
         query_ready_o <= 1'b0;
      end else begin
         state_q       <= state_d;
         query_ready_o <= (state_d == ST_IDLE);
      end
   end

   // reference select follows config, 2.5 V out of reset
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) analog_ref_sel_o <= REF_2V5;
      else analog_ref_sel_o <= analog_reference_select_i;
   end

   // snapshot of configuration and digital lines at query time
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dmask_q  <= '0;
         amask_q  <= '0;
         dstate_q <= '0;
         remote_q <= 1'b0;
         api_q    <= 1'b0;
         dest_q   <= '0;
         fid_q    <= '0;
      end else if (start_query) begin
         dmask_q  <= dig_en;
         amask_q  <= analog_enable_i;
         // unused bits forced low; the reader must ignore them anyway
         dstate_q <= dig_en & {{(16-NUM_LINES){1'b0}}, line_level};
         remote_q <= query_remote_i;
         api_q    <= api_mode_i;
         dest_q   <= query_source_i;
         fid_q    <= query_frame_id_i;
      end
   end

   // conversion sequencing, one channel at a time in channel order
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ch_q          <= '0;
         adc_start_o   <= 1'b0;
         adc_channel_o <= '0;
         an_q          <= '0;
      end else begin
         adc_start_o <= (state_q == ST_CONV) && ch_enabled;
         if (start_query) ch_q <= '0;
         else if ((state_q == ST_CONV && !ch_enabled)
                  || (state_q == ST_WAIT && adc_done_i))
            ch_q <= ch_q + 2'd1;
         if (state_q == ST_CONV) adc_channel_o <= ch_q;
         if (state_q == ST_WAIT && adc_done_i)
            an_q[ch_q] <= adc_sat;
      end
   end

   // emission counters
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         idx_q <= '0;
         ph_q  <= PH_HI;
         hdr_q <= '0;
         sum_q <= '0;
      end else if (start_query) begin
         idx_q <= '0;
         ph_q  <= PH_HI;
         hdr_q <= '0;
         sum_q <= '0;
      end else if (push) begin
         if (in_sum) sum_q <= sum_q + push_word.data;
         if (state_q == ST_HDR) hdr_q <= hdr_q + 3'd1;
         if (state_q == ST_BODY) begin
            if (byte_done) begin
               idx_q <= idx_q + IDX_W'(1);
               ph_q  <= PH_HI;
            end else if (ph_q == PH_HI) begin
               ph_q <= PH_LO;
            end else begin
               ph_q <= PH_CR;
            end
         end
      end
   end
endmodule // io_sample_packet_builder

// file: verif/io_sample_checker_sva.sv
// assertion checker for the I/O sample record builder
`timescale 1ns/10ps
module io_sample_checker
   import io_sample_pkg::*;
(
   input wire logic                 sys_clk_i,
   input wire logic                 rst_i,
   input wire logic [NUM_LINES-1:0] digital_enable_i,
   input wire logic [NUM_AN-1:0]    analog_enable_i,
   input wire logic                 analog_reference_select_i,
   input wire logic                 api_mode_i,
   input wire logic                 sample_query_cmd_i,
   input wire logic [7:0]           query_source_i,
   input wire logic                 query_ready_o,
   input wire logic                 adc_start_o,
   input wire logic [1:0]           adc_channel_o,
   input wire logic                 analog_ref_sel_o,
   input wire logic                 out_valid_o,
   input wire logic [7:0]           out_data_o,
   input wire logic                 out_last_o,
   input wire logic                 out_remote_o,
   input wire logic [7:0]           out_dest_o,
   input wire logic                 out_ready_i
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   logic       take;
   logic       first_q;
   logic       mode_q;
   logic       have_ch_q;
   logic [1:0] last_ch_q;
   logic [7:0] src_q;

   assign take = sample_query_cmd_i && query_ready_o;

   // context of the answer being drained; valid while queries do not overlap
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         first_q   <= 1'b1;
         mode_q    <= 1'b0;
         have_ch_q <= 1'b0;
         last_ch_q <= 2'h0;
         src_q     <= 8'h00;
      end else begin
         if (out_valid_o && out_ready_i) first_q <= out_last_o;
         if (take) mode_q <= api_mode_i;
         if (take) src_q <= query_source_i;
         if (take) have_ch_q <= 1'b0;
         else if (adc_start_o) have_ch_q <= 1'b1;
         if (adc_start_o) last_ch_q <= adc_channel_o;
      end
   end

   chk_ref_follows: assert property (
      !$past(rst_i) |-> analog_ref_sel_o == $past(analog_reference_select_i))
      else $error("converter reference does not follow its setting");
   chk_stall_hold: assert property (
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o)
         && $stable(out_last_o))
      else $error("output byte changed while stalled");
   chk_no_enable_quiet: assert property (
      take && digital_enable_i == 0 && analog_enable_i == 0
         |=> query_ready_o [*4])
      else $error("query with nothing enabled was acted on");
   chk_query_starts: assert property (
      take && (|{digital_enable_i, analog_enable_i}) |=> !query_ready_o)
      else $error("query with enabled lines not taken");
   chk_adc_pulse: assert property (
      adc_start_o |=> !adc_start_o)
      else $error("conversion start longer than one cycle");
   chk_adc_order: assert property (
      adc_start_o && have_ch_q |-> adc_channel_o > last_ch_q)
      else $error("analog channels converted out of order");
   chk_first_remote: assert property (
      out_valid_o && first_q && out_remote_o |-> out_data_o == 8'h01)
      else $error("remote record does not open with count byte");
   chk_first_local: assert property (
      out_valid_o && first_q && !out_remote_o
         |-> out_data_o == (mode_q ? 8'h7E : 8'h30))
      else $error("local answer opens with wrong byte");
   chk_remote_dest: assert property (
      out_valid_o && out_remote_o |-> out_dest_o == src_q)
      else $error("remote byte addressed to wrong node");
   chk_text_last: assert property (
      out_valid_o && out_last_o && !out_remote_o && !mode_q
         |-> out_data_o == 8'h0D)
      else $error("text answer not ended by carriage return");

   cov_remote_end: cover property (out_valid_o && out_last_o && out_remote_o);
   cov_framed: cover property (out_valid_o && first_q && out_data_o == 8'h7E);
   cov_stall: cover property (out_valid_o && !out_ready_i);
endmodule // io_sample_checker

bind io_sample_packet_builder io_sample_checker u_chk (
   .sys_clk_i, .rst_i, .digital_enable_i, .analog_enable_i,
   .analog_reference_select_i, .api_mode_i, .sample_query_cmd_i,
   .query_source_i, .query_ready_o, .adc_start_o, .adc_channel_o,
   .analog_ref_sel_o, .out_valid_o, .out_data_o, .out_last_o,
   .out_remote_o, .out_dest_o, .out_ready_i);

// file: verif/adc_host_model.sv
// converter and host sink model on the far side of the builder
`timescale 1ns/10ps
module adc_host_model
   import io_sample_pkg::*;
(
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  adc_start_i,
   input  wire logic [1:0]            adc_channel_i,
   input  wire logic [4*ADC_W-1:0]    adc_table_i,
   input  wire logic                  slow_i,
   output logic                       adc_done_o = 1'b0,
   output logic      [ADC_W-1:0]      adc_value_o = 12'hA5A,
   output logic                       out_ready_o = 1'b1
);
   logic       busy = 1'b0;
   logic [1:0] ch   = 2'h0;
   int         cnt  = 0;

   // value bus toggles when not valid so a stale sample cannot pass
   always @(negedge sys_clk_i) begin
      adc_done_o  <= 1'b0;
      adc_value_o <= ~adc_value_o;
      out_ready_o <= slow_i ? ($urandom % 3 != 0) : 1'b1;
      if (rst_i) begin
         busy = 1'b0;
      end else if (adc_start_i) begin
         busy = 1'b1;
         ch   = adc_channel_i;
         cnt  = slow_i ? int'($urandom % 12) : 0;
      end else if (busy && cnt == 0) begin
         busy = 1'b0;
         adc_done_o  <= 1'b1;
         adc_value_o <= adc_table_i[ch*ADC_W +: ADC_W];
      end else if (busy) begin
         cnt--;
      end
   end
endmodule // adc_host_model

// file: verif/tb.sv
// self-checking bench for the I/O sample record builder
`timescale 1ns/10ps
module tb
   import io_sample_pkg::*;
;
   logic                 sys_clk_i = 1'b0;
   logic                 rst_i = 1'b1;
   logic [NUM_LINES-1:0] general_line_i, digital_enable_i, dm, ln;
   logic [NUM_AN-1:0]    analog_enable_i, am;
   logic                 analog_reference_select_i, api_mode_i;
   logic                 sample_query_cmd_i, query_remote_i, query_ready_o;
   logic                 adc_start_o, analog_ref_sel_o, adc_done_i;
   logic                 out_valid_o, out_last_o, out_remote_o, out_ready_i;
   logic                 api, rem, rf, slow;
   logic [7:0]           query_source_i, query_frame_id_i, out_data_o;
   logic [7:0]           out_dest_o, src, fid;
   logic [1:0]           adc_channel_o;
   logic [ADC_W-1:0]     adc_value_i;
   logic [ADC_W-1:0]     tab[NUM_AN];
   out_word_t            exp_q[$];
   int                   n_fail = 0;
   int                   comparisons = 0;
   int                   cycles = 0;

   io_sample_packet_builder DUT (
      .sys_clk_i, .rst_i, .general_line_i, .digital_enable_i,
      .analog_enable_i, .analog_reference_select_i, .api_mode_i,
      .sample_query_cmd_i, .query_remote_i, .query_source_i,
      .query_frame_id_i, .query_ready_o, .adc_start_o, .adc_channel_o,
      .analog_ref_sel_o, .adc_done_i, .adc_value_i, .out_valid_o,
      .out_data_o, .out_last_o, .out_remote_o, .out_dest_o, .out_ready_i);

   adc_host_model u_model (
      .sys_clk_i, .rst_i, .adc_start_i(adc_start_o),
      .adc_channel_i(adc_channel_o),
      .adc_table_i({tab[3], tab[2], tab[1], tab[0]}), .slow_i(slow),
      .adc_done_o(adc_done_i), .adc_value_o(adc_value_i),
      .out_ready_o(out_ready_i));

   initial forever #12.5 sys_clk_i = ~sys_clk_i;

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [WORD_W-1:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] hexc(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction

   task automatic put(input logic [7:0] d, input logic l);
      exp_q.push_back(out_word_t'{d, l, rem, rem ? src : 8'h00});
   endtask

   // expected answer bytes for the current configuration
   task automatic build();
      logic [7:0]  rec[$];
      int          fl[$];
      logic [15:0] v;
      logic [7:0]  ck;
      int          k;
      if (dm == 0 && am == 0) return;
      rec = '{8'h01, {3'h0, dm[12:8]}, dm[7:0], {4'h0, am}};
      fl = '{1, 2, 1};
      if (dm != 0) begin
         v = {3'h0, ln & dm};
         rec.push_back(v[15:8]);
         rec.push_back(v[7:0]);
         fl.push_back(2);
      end
      for (int c = 0; c < NUM_AN; c++) begin
         if (am[c]) begin
            v = (tab[c] > 12'h3FF) ? 16'h03FF : {4'h0, tab[c]};
            rec.push_back(v[15:8]);
            rec.push_back(v[7:0]);
            fl.push_back(2);
         end
      end
      if (rem) begin
         foreach (rec[i]) put(rec[i], i == rec.size() - 1);
      end else if (api) begin
         ck = 8'hFF - 8'h88 - fid - 8'h49 - 8'h53;
         put(8'h7E, 0);
         put(8'h00, 0);
         put(8'(5 + rec.size()), 0);
         put(8'h88, 0);
         put(fid, 0);
         put(8'h49, 0);
         put(8'h53, 0);
         put(8'h00, 0);
         foreach (rec[i]) begin
            put(rec[i], 0);
            ck -= rec[i];
         end
         put(ck, 1);
      end else begin
         k = 0;
         foreach (fl[f]) begin
            for (int b = 0; b < fl[f]; b++) begin
               put(hexc(rec[k][7:4]), 0);
               put(hexc(rec[k][3:0]), 0);
               k++;
            end
            put(8'h0D, f == fl.size() - 1);
         end
      end
   endtask

   task automatic run(input string name);
      int t;
      @(negedge sys_clk_i);
      digital_enable_i = dm;
      analog_enable_i = am;
      general_line_i = ln;
      analog_reference_select_i = rf;
      api_mode_i = api;
      repeat (8) @(negedge sys_clk_i);
      check(WORD_W'(analog_ref_sel_o), WORD_W'(rf));
      build();
      t = 0;
      while (query_ready_o !== 1'b1 && t < 500) begin
         @(negedge sys_clk_i);
         t++;
      end
      sample_query_cmd_i = 1'b1;
      query_remote_i = rem;
      query_source_i = src;
      query_frame_id_i = fid;
      @(negedge sys_clk_i);
      sample_query_cmd_i = 1'b0;
      query_remote_i = ~rem;
      query_source_i = ~src;
      query_frame_id_i = ~fid;
      t = 0;
      while ((exp_q.size() != 0 || query_ready_o !== 1'b1) && t < 3000) begin
         @(negedge sys_clk_i);
         t++;
      end
      repeat (30) @(negedge sys_clk_i);
      check(WORD_W'({exp_q.size() == 0, query_ready_o}), WORD_W'(2'h3));
      $display("test %s done", name);
   endtask

   // sink side: every accepted byte is matched against the oldest note
   always @(posedge sys_clk_i) begin
      if (!rst_i && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected none %h", $time,
                     out_data_o, 8'h00);
         end else begin
            check(out_word_t'{out_data_o, out_last_o, out_remote_o, out_remote_o ? out_dest_o : 8'h00}, exp_q.pop_front());
         end
      end
   end

   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         n_fail++;
         final_report();
      end
   end

   initial begin
      int unsigned seed_use;
      seed_use = $urandom(32'h3AB5);
      {general_line_i, digital_enable_i, analog_enable_i} = '0;
      {analog_reference_select_i, api_mode_i, sample_query_cmd_i} = 3'h4;
      {query_remote_i, query_source_i, query_frame_id_i} = '0;
      slow = 1'b0;
      repeat (16) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      dm = 13'h0C0C;
      am = 4'h3;
      ln = 13'h1408;
      tab = '{12'h3D0, 12'h124, 12'hFFF, 12'h000};
      {api, rem, rf, src, fid} = {3'b001, 8'h00, 8'h01};
      run("text example");
      dm = 13'h0000;
      am = 4'hF;
      tab = '{12'hFFF, 12'h400, 12'h3FF, 12'h000};
      {api, rem, rf, slow, src} = {4'b0101, 8'h5C};
      run("remote saturation");
      {dm, am, ln} = {13'h1FFF, 4'h0, 13'h0AB5};
      {api, rem, fid} = {2'b10, 8'hC3};
      run("framed digital");
      {dm, am} = '0;
      run("nothing enabled");
      for (int i = 0; i < 24; i++) begin
         dm = 13'($urandom) & {13{i[0]}};
         am = 4'($urandom) & {4{i[1]}};
         ln = 13'($urandom);
         {api, rem, rf, slow, src, fid} = 20'($urandom);
         foreach (tab[c]) tab[c] = 12'($urandom);
         run("random query");
      end
      final_report();
   end
endmodule // tb
